// >>> mcd_consts.vh
// Purpose: Shared constants of the Manchester command frame decoder
// Assumes: Included by every design file of the block
// Notes: Definitions only
`ifndef MCD_CONSTS_VH
`define MCD_CONSTS_VH

// ***************************************************************
// APB register map
// ***************************************************************
`define MCD_ADDR_CTRL 8'h00
`define MCD_ADDR_STATUS 8'h04
`define MCD_ADDR_PERIOD 8'h08
`define MCD_CTRL_RST 2'h0
`define MCD_CTRL_DIS_BIT 0
`define MCD_CTRL_SPI_BIT 1
`define MCD_ST_COMM_BIT 0
`define MCD_ST_BUSY_BIT 1
`define MCD_ST_AE_BIT 2
`define MCD_ST_OR_BIT 3
`define MCD_ST_CS_BIT 4
`define MCD_ST_SLOT_LO 5

// ***************************************************************
// Frame layout, bits counted after the sync bits
// ***************************************************************
`define MCD_LEN_READ 5'h0E
`define MCD_LEN_WRITE 5'h1E
`define MCD_CRC_BITS 5'h03
`define MCD_RD_TID_HI 12
`define MCD_RD_ADR_HI 8
`define MCD_WR_TID_HI 28
`define MCD_WR_ADR_HI 24
`define MCD_WR_DAT_HI 18
`define MCD_SPECIAL_ADDR 6'h3F
`define MCD_ACCESS_CODE 16'h62D2
`define MCD_CRC_INIT 3'h7

// ***************************************************************
// Response frame
// ***************************************************************
`define MCD_TX_PAYLOAD_BITS 5'h18
`define MCD_TX_LAST_IDX 5'h1A
`define MCD_TX_CRC_FIRST 5'h02
`define MCD_MIN_PERIOD 4

`endif

// >>> mcd_crc3.v
// Purpose: Serial 3-bit CRC, polynomial x^3+x+1
// Assumes: Bits fed MSB first, one per enable
// Notes: Output read as C2 C1 C0
`include "mcd_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module mcd_crc3 (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Feed
	input wire clr,
	input wire en,
	input wire din,
	// Result
	output wire [2:0] crc
);
	reg [2:0] c_q;
	wire fb = c_q[2] ^ din;

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			c_q <= `MCD_CRC_INIT;
		else if (clr)
			c_q <= `MCD_CRC_INIT;
		else if (en)
			c_q <= {c_q[1], c_q[0] ^ fb, fb};
	end

	assign crc = c_q;
endmodule // mcd_crc3
`default_nettype wire

// >>> mcd_resp_tx.v
// Purpose: Manchester read-response transmitter on an open-drain pin
// Assumes: half_per is at least one clock
// Notes: oe high pulls the line low; released line reads high
`include "mcd_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module mcd_resp_tx #(
	parameter CNT_W = 16
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Request
	input wire start,
	input wire [CNT_W-1:0] half_per,
	input wire [23:0] payload,
	// Line
	output wire busy,
	output wire oe
);
	reg busy_q;
	reg oe_q;
	reg half_q;
	reg bit_q;
	reg [4:0] idx_q;
	reg [CNT_W-1:0] tmr_q;
	reg [23:0] pl_q;
	wire [2:0] crc;
	wire [4:0] idx_nx = idx_q + 5'h01;
	wire half_end = busy_q && (tmr_q == half_per - {{(CNT_W-1){1'b0}}, 1'b1});
	wire bit_end = half_end && half_q;
	wire nbit;

	// Bit to send at a given index: payload first, then the CRC
	function sel_bit;
		input [4:0] idx;
		input [23:0] pl;
		input [2:0] c;
		begin
			if (idx < `MCD_TX_PAYLOAD_BITS)
				sel_bit = pl[5'h17 - idx];
			else
				sel_bit = c[2'h2 - idx[1:0]];
		end
	endfunction

	assign nbit = sel_bit(idx_nx, pl_q, crc);

	mcd_crc3 u_crc (
		.clk(clk),
		.rst_n(rst_n),
		.clr(start),
		.en(bit_end && idx_nx >= `MCD_TX_CRC_FIRST && idx_nx < `MCD_TX_PAYLOAD_BITS),
		.din(nbit),
		.crc(crc)
	);

	// ***************************************************************
	// Half-bit sequencer
	// ***************************************************************
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busy_q <= 1'b0;
			oe_q <= 1'b0;
			half_q <= 1'b0;
			bit_q <= 1'b0;
			idx_q <= 5'h00;
			tmr_q <= {CNT_W{1'b0}};
			pl_q <= 24'h000000;
		end
		else if (start && !busy_q)
		begin
			busy_q <= 1'b1;
			pl_q <= payload;
			idx_q <= 5'h00;
			half_q <= 1'b0;
			tmr_q <= {CNT_W{1'b0}};
			bit_q <= payload[23];
			oe_q <= ~payload[23];
		end
		else if (busy_q)
		begin
			if (!half_end)
				tmr_q <= tmr_q + {{(CNT_W-1){1'b0}}, 1'b1};
			else
			begin
				tmr_q <= {CNT_W{1'b0}};
				if (!half_q)
				begin
					half_q <= 1'b1;
					oe_q <= bit_q;
				end
				else if (idx_q == `MCD_TX_LAST_IDX)
				begin
					busy_q <= 1'b0;
					oe_q <= 1'b0;
				end
				else
				begin
					half_q <= 1'b0;
					idx_q <= idx_nx;
					bit_q <= nbit;
					oe_q <= ~nbit;
				end
			end
		end
	end

	assign busy = busy_q;
	assign oe = oe_q;
endmodule // mcd_resp_tx
`default_nettype wire

// >>> mcd_frame_decoder.v
// Purpose: Receiver, parser and addressing of Manchester command frames
// Assumes: supply_line_in is the digitised supply level, idle high
// Notes: Register contents come from reg_rdata one clock after reg_addr
//
// How it works
// - Falling mid-bit edge means one, rising means zero.
// - Frames start with two zero sync bits used to find timing.
// - After sync: read/write, 4-bit target mask, 6-bit address, write data.
// - Every command ends with a 3-bit CRC.
// - Target mask bit for our slot set selects this die.
// - All-zero target mask is a broadcast to every die.
// - Slot number is {MOSI strap, chip-select strap}.
// - Valid addressed read produces a read-response frame on the pulse pin.
// - Response ID is the slot, or zeros when broadcast flag set.
// - Broadcast flag set for all-zero mask or serial-peripheral mode.
// - Edge failure after sync sets abort flag and drops the frame.
// - Command completing while still responding sets overrun flag.
// - Earlier CRC failure sets the checksum error flag.
// - Nothing is acted upon before the access code.
// - Write to 111111 with 0x62D2 enters mode, any target.
// - Write to 111111 with other data leaves mode, any target.
// - Read address selects the register the response returns.
// - CRC x^3+x+1, preset 111, bits after sync, C2 first.
// - Error flags held until reported, then cleared.
// - Odd address read returns low byte only, upper byte zero.
// - Disable bit makes the die ignore all Manchester activity.
`include "mcd_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module mcd_frame_decoder #(
	parameter CNT_W = 16
) (
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Pins
	input wire supply_line_in,
	input wire chip_select_strap_pin,
	input wire mosi_strap_pin,
	output wire resp_pin_out,
	output wire resp_pin_oe,
	// Register bank
	output wire [5:0] reg_addr,
	output wire reg_wr_en,
	output wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata,
	// Mode
	output wire manchester_mode
);
	localparam ST_IDLE = 3'h0;
	localparam ST_S0MID = 3'h1;
	localparam ST_S0END = 3'h2;
	localparam ST_S1MID = 3'h3;
	localparam ST_DATA = 3'h4;
	localparam [CNT_W-1:0] TMR_MAX = {CNT_W{1'b1}};
	localparam [CNT_W-1:0] TMR_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	reg [2:0] pin_s1_q;
	reg [2:0] pin_s2_q;
	reg line_prev_q;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_s1_q <= 3'h7;
			pin_s2_q <= 3'h7;
			line_prev_q <= 1'b1;
		end
		else
		begin
			pin_s1_q <= {mosi_strap_pin, chip_select_strap_pin, supply_line_in};
			pin_s2_q <= pin_s1_q;
			line_prev_q <= pin_s2_q[0];
		end
	end

	wire line_now = pin_s2_q[0];
	wire fall = line_prev_q & ~line_now;
	wire rise = ~line_prev_q & line_now;
	wire [1:0] slot = pin_s2_q[2:1];

	// ***************************************************************
	// Control registers and flags
	// ***************************************************************
	reg [1:0] ctrl_q;
	reg comm_q;
	reg ab_q;
	reg ov_q;
	reg ce_q;
	wire mdis = ctrl_q[`MCD_CTRL_DIS_BIT];
	wire spi_mode = ctrl_q[`MCD_CTRL_SPI_BIT];

	// Frame length after sync, decided by the read/write bit
	function [4:0] frame_len;
		input rw;
		begin
			frame_len = rw ? `MCD_LEN_READ : `MCD_LEN_WRITE;
		end
	endfunction

	// ***************************************************************
	// Receiver
	// ***************************************************************
	reg [2:0] rx_st_q;
	reg [CNT_W-1:0] tmr_q;
	reg [CNT_W-1:0] per_q;
	reg [4:0] nb_q;
	reg [29:0] sh_q;
	reg rw_q;
	reg bnd_q;
	reg done_q;
	reg ab_set_q;
	wire [2:0] rx_crc;

	wire [CNT_W-1:0] quarter = per_q >> 2;
	wire [CNT_W-1:0] win_lo = per_q - quarter;
	wire [CNT_W:0] win_hi = {1'b0, per_q} + {1'b0, quarter};
	wire in_data = (rx_st_q == ST_DATA);
	wire early = tmr_q < win_lo;
	wire mid_hit = in_data && (rise || fall) && !early;
	wire cur_rw = (nb_q == 5'h00) ? fall : rw_q;
	wire [4:0] cur_len = frame_len(cur_rw);
	wire crc_en = mid_hit && (nb_q < cur_len - `MCD_CRC_BITS);
	wire crc_clr = (rx_st_q == ST_S1MID) && rise;
	wire last_bit = mid_hit && (nb_q + 5'h01 == cur_len);
	wire [CNT_W-1:0] tmr_inc = (tmr_q == TMR_MAX) ? tmr_q : tmr_q + TMR_ONE;

	mcd_crc3 u_rx_crc (
		.clk(pclk),
		.rst_n(presetn),
		.clr(crc_clr),
		.en(crc_en),
		.din(fall),
		.crc(rx_crc)
	);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_st_q <= ST_IDLE;
			tmr_q <= {CNT_W{1'b0}};
			per_q <= {CNT_W{1'b0}};
			nb_q <= 5'h00;
			sh_q <= 30'h00000000;
			rw_q <= 1'b0;
			bnd_q <= 1'b0;
			done_q <= 1'b0;
			ab_set_q <= 1'b0;
		end
		else
		begin
			done_q <= last_bit;
			ab_set_q <= 1'b0;
			tmr_q <= tmr_inc;
			if (mdis)
				rx_st_q <= ST_IDLE;
			else
			begin
				case (rx_st_q)
				ST_IDLE:
				begin
					tmr_q <= {CNT_W{1'b0}};
					if (fall)
						rx_st_q <= ST_S0MID;
				end
				ST_S0MID:
				begin
					if (rise)
						rx_st_q <= ST_S0END;
					else if (tmr_q == TMR_MAX)
						rx_st_q <= ST_IDLE;
				end
				ST_S0END:
				begin
					if (fall)
					begin
						per_q <= tmr_inc;
						tmr_q <= {CNT_W{1'b0}};
						if (tmr_inc < `MCD_MIN_PERIOD)
							rx_st_q <= ST_IDLE;
						else
							rx_st_q <= ST_S1MID;
					end
					else if (tmr_q == TMR_MAX)
						rx_st_q <= ST_IDLE;
				end
				ST_S1MID:
				begin
					if (rise)
					begin
						tmr_q <= {CNT_W{1'b0}};
						nb_q <= 5'h00;
						bnd_q <= 1'b0;
						if (tmr_q >= quarter && tmr_q < win_lo)
							rx_st_q <= ST_DATA;
						else
							rx_st_q <= ST_IDLE;
					end
					else if (tmr_q >= win_lo)
						rx_st_q <= ST_IDLE;
				end
				ST_DATA:
				begin
					if (rise || fall)
					begin
						if (early)
						begin
							bnd_q <= 1'b1;
							if (bnd_q)
							begin
								ab_set_q <= 1'b1;
								rx_st_q <= ST_IDLE;
							end
						end
						else
						begin
							sh_q <= {sh_q[28:0], fall};
							if (nb_q == 5'h00)
								rw_q <= fall;
							nb_q <= nb_q + 5'h01;
							tmr_q <= {CNT_W{1'b0}};
							bnd_q <= 1'b0;
							if (last_bit)
								rx_st_q <= ST_IDLE;
						end
					end
					else if ({1'b0, tmr_q} > win_hi)
					begin
						ab_set_q <= 1'b1;
						rx_st_q <= ST_IDLE;
					end
				end
				default:
					rx_st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ***************************************************************
	// Frame decode
	// ***************************************************************
	wire [3:0] tid = rw_q ? sh_q[`MCD_RD_TID_HI -: 4] : sh_q[`MCD_WR_TID_HI -: 4];
	wire [5:0] fadr = rw_q ? sh_q[`MCD_RD_ADR_HI -: 6] : sh_q[`MCD_WR_ADR_HI -: 6];
	wire [15:0] fdat = sh_q[`MCD_WR_DAT_HI -: 16];
	wire crc_ok = (sh_q[2:0] == rx_crc);
	wire bcast = (tid == 4'h0);
	wire selected = bcast || tid[slot];
	wire special = !rw_q && (fadr == `MCD_SPECIAL_ADDR);
	wire tx_busy;
	reg fetch_q;
	reg odd_q;
	reg bc_q;
	reg [5:0] radr_q;
	reg wr_q;
	reg [15:0] wdat_q;
	wire busy_any = tx_busy || fetch_q;
	wire take = done_q && !busy_any && crc_ok;
	wire ov_set = done_q && busy_any;
	wire ce_set = done_q && !busy_any && !crc_ok;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			comm_q <= 1'b0;
			fetch_q <= 1'b0;
			odd_q <= 1'b0;
			bc_q <= 1'b0;
			radr_q <= 6'h00;
			wr_q <= 1'b0;
			wdat_q <= 16'h0000;
			ab_q <= 1'b0;
			ov_q <= 1'b0;
			ce_q <= 1'b0;
		end
		else
		begin
			fetch_q <= 1'b0;
			wr_q <= 1'b0;
			// New errors win over the clear done when a response loads
			ab_q <= ab_set_q | (ab_q & ~fetch_q);
			ov_q <= ov_set | (ov_q & ~fetch_q);
			ce_q <= ce_set | (ce_q & ~fetch_q);
			if (take && special)
				comm_q <= (fdat == `MCD_ACCESS_CODE);
			else if (take && comm_q && selected)
			begin
				if (rw_q)
				begin
					radr_q <= {fadr[5:1], 1'b0};
					odd_q <= fadr[0];
					bc_q <= bcast || spi_mode;
					fetch_q <= 1'b1;
				end
				else
				begin
					radr_q <= fadr;
					wdat_q <= fdat;
					wr_q <= 1'b1;
				end
			end
		end
	end

	// ***************************************************************
	// Response
	// ***************************************************************
	wire [15:0] rdat = odd_q ? {8'h00, reg_rdata[7:0]} : reg_rdata;
	wire [1:0] rid = bc_q ? 2'h0 : slot;
	wire [23:0] payload = {2'h0, rid, bc_q, ab_q, ov_q, ce_q, rdat};
	wire [CNT_W-1:0] half_raw = per_q >> 1;
	wire [CNT_W-1:0] half_per = (half_raw == {CNT_W{1'b0}}) ? TMR_ONE : half_raw;
	wire tx_oe;
	reg oe_q;

	mcd_resp_tx #(
		.CNT_W(CNT_W)
	) u_tx (
		.clk(pclk),
		.rst_n(presetn),
		.start(fetch_q),
		.half_per(half_per),
		.payload(payload),
		.busy(tx_busy),
		.oe(tx_oe)
	);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			oe_q <= 1'b0;
		else
			oe_q <= tx_oe;
	end

	// ***************************************************************
	// APB slave
	// ***************************************************************
	reg [31:0] prdata_q;
	reg pready_q;
	reg pslverr_q;
	wire apb_done = psel && penable && pready_q;
	reg [31:0] rd_mux;
	reg rd_err;

	always @*
	begin
		rd_mux = 32'h00000000;
		rd_err = 1'b0;
		case (paddr)
		`MCD_ADDR_CTRL:
			rd_mux[1:0] = ctrl_q;
		`MCD_ADDR_STATUS:
		begin
			rd_mux[`MCD_ST_COMM_BIT] = comm_q;
			rd_mux[`MCD_ST_BUSY_BIT] = busy_any;
			rd_mux[`MCD_ST_AE_BIT] = ab_q;
			rd_mux[`MCD_ST_OR_BIT] = ov_q;
			rd_mux[`MCD_ST_CS_BIT] = ce_q;
			rd_mux[`MCD_ST_SLOT_LO +: 2] = slot;
		end
		`MCD_ADDR_PERIOD:
			rd_mux[CNT_W-1:0] = per_q;
		default:
			rd_err = 1'b1;
		endcase
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= `MCD_CTRL_RST;
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			pready_q <= psel && !penable;
			pslverr_q <= psel && !penable && rd_err;
			prdata_q <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
			if (apb_done && pwrite && paddr == `MCD_ADDR_CTRL)
				ctrl_q <= pwdata[1:0];
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	reg out_q;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_q <= 1'b0;
		else
			out_q <= 1'b0;
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign resp_pin_out = out_q;
	assign resp_pin_oe = oe_q;
	assign reg_addr = radr_q;
	assign reg_wr_en = wr_q;
	assign reg_wdata = wdat_q;
	assign manchester_mode = comm_q;
endmodule // mcd_frame_decoder
`default_nettype wire

// >>> mcd_frame_decoder_assertions.sv
// Purpose: Port checker for the Manchester command frame decoder
// Assumes: Sees only the top module's ports
// Notes: Bound to the decoder at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module mcd_frame_decoder_chk #(
	parameter CNT_W = 16
) (
	// Bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and bank
	input wire logic resp_pin_out,
	input wire logic resp_pin_oe,
	input wire logic [5:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [15:0] reg_wdata,
	input wire logic manchester_mode
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;
	property p_pready_setup;
		psel && !penable |=> pready;
	endproperty
	a_pready_setup: assert property (p_pready_setup) else $error("no pready after setup");
	property p_pready_pulse;
		pready |=> !pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse) else $error("pready held");
	property p_prdata_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	a_prdata_idle: assert property (p_prdata_idle) else $error("prdata not zero when idle");
	property p_slverr_map;
		pready |-> pslverr == !mapped;
	endproperty
	a_slverr_map: assert property (p_slverr_map) else $error("pslverr wrong for address");
	property p_oe_mode;
		$rose(resp_pin_oe) |-> manchester_mode;
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("response outside mode");
	property p_wr_pulse;
		reg_wr_en |=> !reg_wr_en;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe held");
	property p_wr_hold;
		reg_wr_en |=> $stable(reg_addr) && $stable(reg_wdata);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write fields moved");
	property p_oe_half;
		$changed(resp_pin_oe) |=> $stable(resp_pin_oe);
	endproperty
	a_oe_half: assert property (p_oe_half) else $error("half bit too short");
	property p_out_zero;
		resp_pin_out == 1'b0;
	endproperty
	a_out_zero: assert property (p_out_zero) else $error("pin data not low");
endmodule // mcd_frame_decoder_chk
bind mcd_frame_decoder mcd_frame_decoder_chk #(.CNT_W(CNT_W)) u_chk (.pclk, .presetn, .psel,
	.penable, .paddr, .prdata, .pready, .pslverr, .resp_pin_out, .resp_pin_oe, .reg_addr,
	.reg_wr_en, .reg_wdata, .manchester_mode);
`default_nettype wire

// >>> mcd_host_model.sv
// Purpose: Programming controller on the supply line
// Assumes: Supply idle high; response line pulled up
// Notes: Bit period PER clocks in two equal halves
`timescale 1ns/1ps
`default_nettype none
module mcd_host_model #(
	parameter int PER = 40
) (
	// Clock
	input wire logic pclk,
	// Lines
	output logic supply_line,
	input wire logic resp_line
);
	initial supply_line = 1'b1;
	function automatic logic [2:0] crc3(input logic [26:0] p, input int n);
		logic [2:0] c;
		logic d;
		c = 3'h7;
		for (int i = n - 1; i >= 0; i--)
		begin
			d = c[2] ^ p[i];
			c = {c[1], c[0] ^ d, d};
		end
		return c;
	endfunction
	// Sync pair, n payload bits, CRC; cut ends the frame early
	task automatic send(input logic [26:0] p, input int n, input logic bad, input int cut);
		logic [31:0] f;
		f = {2'h0, p, crc3(p, n) ^ {2'h0, bad}};
		for (int i = n + 4; i > n + 4 - cut; i--)
		begin
			supply_line <= f[i];
			repeat (PER / 2) @(posedge pclk);
			supply_line <= ~f[i];
			repeat (PER / 2) @(posedge pclk);
		end
		supply_line <= 1'b1;
		repeat (PER / 2) @(posedge pclk);
	endtask
	// Cell value is the level of its first half
	task automatic recv(output logic [26:0] r, output logic got);
		int n;
		r = '0;
		for (n = 0; resp_line !== 1'b0 && n < 1000; n++)
			@(posedge pclk);
		got = n < 1000;
		if (got)
		begin
			repeat (PER / 4) @(posedge pclk);
			for (int i = 0; i < 27; i++)
			begin
				r = {r[25:0], resp_line};
				repeat (PER) @(posedge pclk);
			end
		end
	endtask
endmodule // mcd_host_model
`default_nettype wire

// >>> manchester_command_frame_decoder_bench.sv
// Purpose: Self-checking bench for the Manchester command frame decoder
// Assumes: Die strapped to slot 2; bank word built from its address
// Notes: Bit period 40 clocks
`timescale 1ns/1ps
`default_nettype none
module manchester_command_frame_decoder_bench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, resp_pin_out, resp_pin_oe, reg_wr_en, manchester_mode, supply;
	logic [5:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic cs_strap = 1'b0;
	logic mosi_strap = 1'b1;
	logic [1:0] slot_exp = 2'h2;
	int fail_count = 0;
	int check_count = 0;
	always #20 pclk = ~pclk;
	assign reg_rdata = {reg_addr, 4'hC, reg_addr};
	mcd_frame_decoder #(.CNT_W(12)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .supply_line_in(supply),
		.chip_select_strap_pin(cs_strap), .mosi_strap_pin(mosi_strap), .resp_pin_out(resp_pin_out),
		.resp_pin_oe(resp_pin_oe), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .manchester_mode(manchester_mode));
	mcd_host_model #(.PER(40)) host (.pclk(pclk), .supply_line(supply),
		.resp_line(!resp_pin_oe));
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (n = 0; pready !== 1'b1 && n < 20; n++)
			@(posedge pclk);
		if (pready !== 1'b1)
		begin
			fail_count++;
			finish_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [3:0] t, input logic [5:0] a, input logic [15:0] d);
		host.send({1'b0, t, a, d}, 27, 1'b0, 32);
		repeat (10) @(posedge pclk);
	endtask
	// Read command; fl is {broadcast, abort, overrun, checksum}
	task automatic rdm(input logic [3:0] t, input logic [5:0] a, input logic bad,
		input logic [3:0] fl, input logic want);
		logic [26:0] r;
		logic g;
		logic [5:0] e;
		logic [21:0] x;
		fork
			host.send({16'h0, 1'b1, t, a}, 11, bad, 16);
			host.recv(r, g);
		join
		e = {a[5:1], 1'b0};
		x = {fl[3] ? 2'b00 : slot_exp, fl, a[0] ? {10'h0, e} : {e, 4'hC, e}};
		check(g, want);
		if (want)
			check(r, {2'b00, x, host.crc3({5'h0, x}, 22)});
		repeat (60) @(posedge pclk);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		logic [31:0] d;
		logic e;
		apb(1'b0, 8'h00, 32'h0, d, e);
		check(d, 32'h0);
		apb(1'b0, 8'h04, 32'h0, d, e);
		check(d, 32'h40);
		apb(1'b1, 8'h0C, 32'h5, d, e);
		check(e, 1'b1);
		rdm(4'h4, 6'h20, 1'b0, 4'h0, 1'b0);
		$display("test regs done");
	endtask
	task automatic t_mode;
		logic [31:0] d;
		logic e;
		apb(1'b1, 8'h00, 32'h1, d, e);
		wr(4'h1, 6'h3F, 16'h62D2);
		check(manchester_mode, 1'b0);
		apb(1'b1, 8'h00, 32'h0, d, e);
		wr(4'h1, 6'h3F, 16'h62D2);
		check(manchester_mode, 1'b1);
		apb(1'b0, 8'h08, 32'h0, d, e);
		check(d, 32'd40);
		$display("test mode done");
	endtask
	task automatic t_read;
		logic [31:0] d;
		logic e;
		rdm(4'h4, 6'h20, 1'b0, 4'h0, 1'b1);
		rdm(4'h6, 6'h15, 1'b0, 4'h0, 1'b1);
		rdm(4'h0, 6'h21, 1'b0, 4'h8, 1'b1);
		rdm(4'hB, 6'h20, 1'b0, 4'h0, 1'b0);
		apb(1'b1, 8'h00, 32'h2, d, e);
		rdm(4'h4, 6'h30, 1'b0, 4'h8, 1'b1);
		apb(1'b1, 8'h00, 32'h0, d, e);
		$display("test read done");
	endtask
	task automatic t_slot;
		logic [31:0] d;
		logic e;
		cs_strap <= 1'b1;
		mosi_strap <= 1'b0;
		slot_exp = 2'h1;
		repeat (4) @(posedge pclk);
		apb(1'b0, 8'h04, 32'h0, d, e);
		check(d, 32'h21);
		rdm(4'h2, 6'h20, 1'b0, 4'h0, 1'b1);
		rdm(4'h4, 6'h20, 1'b0, 4'h0, 1'b0);
		cs_strap <= 1'b0;
		mosi_strap <= 1'b1;
		slot_exp = 2'h2;
		repeat (4) @(posedge pclk);
		$display("test slot done");
	endtask
	task automatic t_reset;
		logic [31:0] d;
		logic e;
		wr(4'h1, 6'h3F, 16'h62D2);
		check(manchester_mode, 1'b1);
		apb(1'b1, 8'h00, 32'h3, d, e);
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		check(manchester_mode, 1'b0);
		@(posedge pclk);
		apb(1'b0, 8'h00, 32'h0, d, e);
		check(d, 32'h0);
		apb(1'b0, 8'h08, 32'h0, d, e);
		check(d, 32'h0);
		rdm(4'h4, 6'h20, 1'b0, 4'h0, 1'b0);
		$display("test reset done");
	endtask
	task automatic t_errors;
		rdm(4'h4, 6'h10, 1'b1, 4'h0, 1'b0);
		rdm(4'h4, 6'h10, 1'b0, 4'h1, 1'b1);
		rdm(4'h4, 6'h10, 1'b0, 4'h0, 1'b1);
		host.send({16'h0, 1'b1, 4'h4, 6'h10}, 11, 1'b0, 8);
		repeat (100) @(posedge pclk);
		rdm(4'h4, 6'h12, 1'b0, 4'h4, 1'b1);
		host.send({16'h0, 1'b1, 4'h4, 6'h12}, 11, 1'b0, 16);
		host.send({16'h0, 1'b1, 4'h4, 6'h12}, 11, 1'b0, 16);
		repeat (1200) @(posedge pclk);
		rdm(4'h4, 6'h12, 1'b0, 4'h2, 1'b1);
		$display("test errors done");
	endtask
	task automatic t_write;
		logic [5:0] a;
		logic [15:0] d;
		int n;
		n = 0;
		fork
			host.send({1'b0, 4'h4, 6'h05, 16'hA5C3}, 27, 1'b0, 32);
			begin
				for (n = 0; reg_wr_en !== 1'b1 && n < 1500; n++)
					@(posedge pclk);
				a = reg_addr;
				d = reg_wdata;
			end
		join
		if (n >= 1500)
		begin
			fail_count++;
			finish_test();
		end
		check(a, 6'h05);
		check(d, 16'hA5C3);
		wr(4'h1, 6'h3F, 16'h0000);
		check(manchester_mode, 1'b0);
		rdm(4'h4, 6'h20, 1'b0, 4'h0, 1'b0);
		$display("test write done");
	endtask
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_mode();
		t_read();
		t_slot();
		t_errors();
		t_write();
		t_reset();
		finish_test();
	end
	initial
	begin
		repeat (90000) @(posedge pclk);
		fail_count++;
		finish_test();
	end
endmodule // manchester_command_frame_decoder_bench
`default_nettype wire
